// *** rtl/lnp_pkg.sv ***
// Shared constants and carrier types of the line port system interface.
// Assumes a 25 MHz reference clock and a T1-rate line bit period for the time thresholds.
package lnp_pkg;
   localparam int REF_CLK_MHZ     = 25;
   localparam int LINE_BIT_NS     = 648;
   localparam int CNT_W           = 12;
   // Select-pin run length, in transmit clock cycles
   localparam int UBS_LIMIT       = 16;
   // Transmit clock stuck high: 16 line bit periods, least time
   localparam int SHAPE_STUCK_NS  = 16 * LINE_BIT_NS;
   localparam int SHAPE_STUCK_CYC = (SHAPE_STUCK_NS * REF_CLK_MHZ + 999) / 1000;
   // Transmit clock stuck low: one line bit period, least time
   localparam int DRV_IDLE_NS     = LINE_BIT_NS;
   localparam int DRV_IDLE_CYC    = (DRV_IDLE_NS * REF_CLK_MHZ + 999) / 1000;
   // Loss of signal: no mark for 175 bit periods; clear window of equal length
   localparam int LOS_DETECT_NS   = 175 * LINE_BIT_NS;
   localparam int LOS_DETECT_CYC  = (LOS_DETECT_NS * REF_CLK_MHZ + 999) / 1000;
   localparam int LOS_CLEAR_MARKS = 32;
   localparam int FIFO_DEPTH      = 4;
   localparam int ZRUN_SUB        = 3;

   typedef struct packed {
      logic pos;
      logic neg;
   } lnp_sym_t;

   typedef enum logic [1:0] {SLOT_SPACE, SLOT_MARK, SLOT_BAL, SLOT_VIOL} lnp_slot_t;

   typedef enum logic {LOS_OK, LOS_LOST} lnp_los_st_t;

   typedef struct packed {
      logic mclk_held_high;
      logic mclk_held_low;
      logic clock_edge_select;
      logic code_select;
      logic gcr_code_select;
      logic gcr_alarm_insert_enable;
      logic host_mode;
      logic bus_multiplex_select;
      logic rx_line_pos;
      logic rx_line_neg;
      logic rx_recovered_clk;
      logic tx_line_clock;
      logic unipolar;
   } lnp_async_t;
endpackage

// *** rtl/lnp_line_port.sv ***
// Line port system interface: transmit decode/encode, clock crossing FIFO, receive outputs, loss of signal.
// Assumes sliced receive pulses and a recovered clock from the analog front end, all asynchronous.
`timescale 1ns/1ps

module lnp_async_fifo #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 4
) (
   input  wire logic             wr_clk_i,
   input  wire logic             wr_rst_i,
   input  wire logic             wr_valid_i,
   output logic                  wr_ready_o,
   input  wire logic [WIDTH-1:0] wr_data_i,
   input  wire logic             rd_clk_i,
   input  wire logic             rd_rst_i,
   output logic                  rd_valid_o,
   input  wire logic             rd_ready_i,
   output logic      [WIDTH-1:0] rd_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0]      wbin_ff, wgray_ff, rbin_ff, rgray_ff;
   logic [AW:0]      rgray_meta_ff, rgray_sync_ff, wgray_meta_ff, wgray_sync_ff;
   logic [AW:0]      nxt_wbin, nxt_rbin;
   logic             do_wr, do_rd;

   // Write side runs on the falling edge of the transmit clock
   assign wr_ready_o = (wgray_ff != {~rgray_sync_ff[AW:AW-1], rgray_sync_ff[AW-2:0]});
   assign do_wr      = wr_valid_i & wr_ready_o;
   assign nxt_wbin   = wbin_ff + (AW+1)'(do_wr);
   always_ff @(negedge wr_clk_i) begin
      if (wr_rst_i) begin
         wbin_ff  <= '0;
         wgray_ff <= '0;
      end else begin
         wbin_ff  <= nxt_wbin;
         wgray_ff <= nxt_wbin ^ (nxt_wbin >> 1);
      end
   end
   always_ff @(negedge wr_clk_i) begin
      if (do_wr) begin
         mem_ff[wbin_ff[AW-1:0]] <= wr_data_i;
      end
   end
   always_ff @(negedge wr_clk_i) begin
      rgray_meta_ff <= rgray_ff;
      rgray_sync_ff <= rgray_meta_ff;
   end

   assign rd_valid_o = (rgray_ff != wgray_sync_ff);
   assign do_rd      = rd_valid_o & rd_ready_i;
   assign nxt_rbin   = rbin_ff + (AW+1)'(do_rd);
   assign rd_data_o  = mem_ff[rbin_ff[AW-1:0]];
   always_ff @(posedge rd_clk_i) begin
      if (rd_rst_i) begin
         rbin_ff  <= '0;
         rgray_ff <= '0;
      end else begin
         rbin_ff  <= nxt_rbin;
         rgray_ff <= nxt_rbin ^ (nxt_rbin >> 1);
      end
   end
   always_ff @(posedge rd_clk_i) begin
      wgray_meta_ff <= wgray_ff;
      wgray_sync_ff <= wgray_meta_ff;
   end
endmodule

// Contract
// - Select pin high over 16 cycles: unipolar
// - Unipolar coding: zero substitution or plain AMI
// - Receive clock recovered; master clock during loss
// - Master clock high: receive clock is data XOR
// - Master clock low: receive clock high impedance
// - Master clock low: receive data high impedance
// - Clock recovery: NRZ outputs per pulse polarity
// - Data valid on edge chosen by select
// - Data recovery: RZ outputs, polarity from select
// - Unipolar: data on positive pin, violation flag
// - Hardware mode: outputs stay active during loss
// - Host mode: optional all-ones alarm during loss
// - Loss flag on silence, cleared by enough marks
// - Bus multiplex select steers host interface mode
// - Sample on falling edge; clock low tristates driver
// - Clock high over 16 cycles disables shaping
module lnp_line_port
   import lnp_pkg::*;
(
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   input  wire logic tx_line_clock_i,
   input  wire logic tx_positive_data_i,
   input  wire logic tx_negative_data_i,
   output logic      tx_ready_o,
   input  wire logic code_select_i,
   input  wire logic host_mode_i,
   input  wire logic gcr_code_select_i,
   input  wire logic gcr_alarm_insert_enable_i,
   output logic      tx_line_pos_o,
   output logic      tx_line_neg_o,
   output logic      tx_line_oe_o,
   output logic      tx_shaping_disable_o,
   output logic      unipolar_mode_o,
   input  wire logic mclk_held_high_i,
   input  wire logic mclk_held_low_i,
   input  wire logic clock_edge_select_i,
   input  wire logic rx_line_pos_i,
   input  wire logic rx_line_neg_i,
   input  wire logic rx_recovered_clk_i,
   output logic      rx_clock_o,
   output logic      rx_clock_oe_o,
   output logic      rx_positive_data_o,
   output logic      rx_negative_data_o,
   output logic      rx_data_oe_o,
   output logic      signal_loss_flag_o,
   input  wire logic bus_multiplex_select_i,
   output logic      host_bus_muxed_o
);
   // ---------------- Transmit clock domain ----------------
   logic            tx_rst_meta_ff, tx_rst_ff, tx_zsub_meta_ff, tx_zsub_ff, zsub_ff;
   logic [4:0]      ubs_cnt_ff;
   logic            uni_tx_ff, marks_odd_ff, last_pol_ff;
   lnp_slot_t       slot_ff [4];
   lnp_slot_t       in_slot, out_slot;
   logic            do_sub, wr_ready;
   lnp_sym_t        wr_sym, enc_sym;

   always_ff @(negedge tx_line_clock_i) begin
      tx_rst_meta_ff  <= rst_i;
      tx_rst_ff       <= tx_rst_meta_ff;
      tx_zsub_meta_ff <= zsub_ff;
      tx_zsub_ff      <= tx_zsub_meta_ff;
   end

   always_ff @(negedge tx_line_clock_i) begin
      if (tx_rst_ff) begin
         ubs_cnt_ff <= '0;
         uni_tx_ff  <= 1'b0;
      end else begin
         if (!tx_negative_data_i) begin
            ubs_cnt_ff <= '0;
         end else if (ubs_cnt_ff <= 5'(UBS_LIMIT)) begin
            ubs_cnt_ff <= ubs_cnt_ff + 5'h01;
         end
         uni_tx_ff <= tx_negative_data_i && (ubs_cnt_ff >= 5'(UBS_LIMIT));
      end
   end

   // Zero substitution looks back over three held slots and rewrites the run
   assign in_slot  = tx_positive_data_i ? SLOT_MARK : SLOT_SPACE;
   assign do_sub   = tx_zsub_ff && !tx_positive_data_i && slot_ff[0] == SLOT_SPACE
                     && slot_ff[1] == SLOT_SPACE && slot_ff[2] == SLOT_SPACE;
   assign out_slot = slot_ff[3];

   always_ff @(negedge tx_line_clock_i) begin
      if (tx_rst_ff) begin
         for (int i = 0; i < 4; i++) begin
            slot_ff[i] <= SLOT_SPACE;
         end
         marks_odd_ff <= 1'b0;
         last_pol_ff  <= 1'b0;
      end else if (wr_ready) begin
         slot_ff[0] <= do_sub ? SLOT_VIOL : in_slot;
         slot_ff[1] <= slot_ff[0];
         slot_ff[2] <= slot_ff[1];
         slot_ff[3] <= (do_sub && !marks_odd_ff) ? SLOT_BAL : slot_ff[2];
         if (do_sub) begin
            marks_odd_ff <= 1'b0;
         end else if (tx_positive_data_i) begin
            marks_odd_ff <= !marks_odd_ff;
         end
         if (out_slot == SLOT_MARK || out_slot == SLOT_BAL) begin
            last_pol_ff <= !last_pol_ff;
         end
      end
   end

   always_comb begin
      case (out_slot)
         SLOT_MARK, SLOT_BAL: enc_sym = '{pos: !last_pol_ff, neg: last_pol_ff};
         SLOT_VIOL:           enc_sym = '{pos: last_pol_ff, neg: !last_pol_ff};
         default:             enc_sym = '{pos: 1'b0, neg: 1'b0};
      endcase
   end

   // Bipolar decode: equal inputs are a space
   assign wr_sym     = uni_tx_ff ? enc_sym
                       : '{pos: tx_positive_data_i & !tx_negative_data_i,
                           neg: tx_negative_data_i & !tx_positive_data_i};
   assign tx_ready_o = wr_ready;

   // ---------------- Reference clock domain ----------------
   lnp_async_t      async_in, meta_ff, sync_ff;
   lnp_sym_t        rd_sym;
   logic            rd_valid, drive_en;
   logic [CNT_W-1:0] hi_cnt_ff, lo_cnt_ff, idle_cnt_ff, win_cnt_ff;
   logic [5:0]      mk_cnt_ff;
   lnp_los_st_t     los_st_ff;
   logic            mclk_div_ff, rclk_ff, nxt_rclk, launch, signal_loss_flag;
   logic            prev_pos_ff, prev_neg_ff, mark_pos, mark_neg, any_mark;
   logic            pend_pos_ff, pend_neg_ff, rx_last_pol_ff, ais_pol_ff, ais;
   logic [1:0]      zeros_ff;
   logic            rx_mark, same_pol, viol, sub_v, data_rec;
   logic            rx_pos_ff, rx_neg_ff;

   assign async_in = '{mclk_held_high: mclk_held_high_i, mclk_held_low: mclk_held_low_i,
                       clock_edge_select: clock_edge_select_i, code_select: code_select_i,
                       gcr_code_select: gcr_code_select_i,
                       gcr_alarm_insert_enable: gcr_alarm_insert_enable_i,
                       host_mode: host_mode_i, bus_multiplex_select: bus_multiplex_select_i,
                       rx_line_pos: rx_line_pos_i, rx_line_neg: rx_line_neg_i,
                       rx_recovered_clk: rx_recovered_clk_i, tx_line_clock: tx_line_clock_i,
                       unipolar: uni_tx_ff};

   always_ff @(posedge ref_clk_i) begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         zsub_ff <= 1'b0;
      end else begin
         zsub_ff <= sync_ff.host_mode ? sync_ff.gcr_code_select : sync_ff.code_select;
      end
   end

   // Transmit clock level watchdogs
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || !sync_ff.tx_line_clock) begin
         hi_cnt_ff <= '0;
      end else if (hi_cnt_ff < CNT_W'(SHAPE_STUCK_CYC)) begin
         hi_cnt_ff <= hi_cnt_ff + 1'b1;
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || sync_ff.tx_line_clock) begin
         lo_cnt_ff <= '0;
      end else if (lo_cnt_ff < CNT_W'(DRV_IDLE_CYC)) begin
         lo_cnt_ff <= lo_cnt_ff + 1'b1;
      end
   end
   assign tx_shaping_disable_o = (hi_cnt_ff >= CNT_W'(SHAPE_STUCK_CYC));
   assign drive_en             = (lo_cnt_ff < CNT_W'(DRV_IDLE_CYC));

   // Line symbols drain only while the driver is enabled
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         tx_line_pos_o <= 1'b0;
         tx_line_neg_o <= 1'b0;
         tx_line_oe_o  <= 1'b0;
      end else begin
         tx_line_pos_o <= rd_valid & drive_en & rd_sym.pos;
         tx_line_neg_o <= rd_valid & drive_en & rd_sym.neg;
         tx_line_oe_o  <= drive_en;
      end
   end

   lnp_async_fifo #(
      .WIDTH ($bits(lnp_sym_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .wr_clk_i   (tx_line_clock_i),
      .wr_rst_i   (tx_rst_ff),
      .wr_valid_i (!tx_rst_ff),
      .wr_ready_o (wr_ready),
      .wr_data_i  (wr_sym),
      .rd_clk_i   (ref_clk_i),
      .rd_rst_i   (rst_i),
      .rd_valid_o (rd_valid),
      .rd_ready_i (drive_en),
      .rd_data_o  (rd_sym)
   );

   // Receive mark detection on synchronised pulses
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         prev_pos_ff <= 1'b0;
         prev_neg_ff <= 1'b0;
      end else begin
         prev_pos_ff <= sync_ff.rx_line_pos;
         prev_neg_ff <= sync_ff.rx_line_neg;
      end
   end
   assign mark_pos = sync_ff.rx_line_pos & !prev_pos_ff;
   assign mark_neg = sync_ff.rx_line_neg & !prev_neg_ff;
   assign any_mark = mark_pos | mark_neg;

   // Loss of signal: silence sets, enough marks in one window clears
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         los_st_ff   <= LOS_OK;
         idle_cnt_ff <= '0;
         win_cnt_ff  <= '0;
         mk_cnt_ff   <= '0;
      end else begin
         case (los_st_ff)
            LOS_OK: begin
               idle_cnt_ff <= any_mark ? '0 : idle_cnt_ff + 1'b1;
               win_cnt_ff  <= '0;
               mk_cnt_ff   <= '0;
               if (!any_mark && idle_cnt_ff == CNT_W'(LOS_DETECT_CYC - 1)) begin
                  los_st_ff <= LOS_LOST;
               end
            end
            default: begin
               idle_cnt_ff <= '0;
               if (win_cnt_ff == CNT_W'(LOS_DETECT_CYC - 1)) begin
                  win_cnt_ff <= '0;
                  mk_cnt_ff  <= '0;
                  if (mk_cnt_ff >= 6'(LOS_CLEAR_MARKS)) begin
                     los_st_ff <= LOS_OK;
                  end
               end else begin
                  win_cnt_ff <= win_cnt_ff + 1'b1;
                  if (any_mark && mk_cnt_ff != 6'h3F) begin
                     mk_cnt_ff <= mk_cnt_ff + 6'h01;
                  end
               end
            end
         endcase
      end
   end
   assign signal_loss_flag                = (los_st_ff == LOS_LOST);
   assign signal_loss_flag_o = signal_loss_flag;

   // Receive clock source selection
   assign data_rec = sync_ff.mclk_held_high;
   always_comb begin
      if (data_rec) begin
         nxt_rclk = sync_ff.rx_line_pos ^ sync_ff.rx_line_neg;
      end else if (signal_loss_flag) begin
         nxt_rclk = mclk_div_ff;
      end else begin
         nxt_rclk = sync_ff.rx_recovered_clk;
      end
   end
   // Data changes on the edge opposite the one the partner samples
   assign launch = sync_ff.clock_edge_select ? (rclk_ff & !nxt_rclk) : (!rclk_ff & nxt_rclk);

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         mclk_div_ff <= 1'b0;
         rclk_ff     <= 1'b0;
      end else begin
         mclk_div_ff <= !mclk_div_ff;
         rclk_ff     <= nxt_rclk;
      end
   end

   // Pending pulses between launches; a new mark wins over the clear
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pend_pos_ff <= 1'b0;
         pend_neg_ff <= 1'b0;
      end else begin
         pend_pos_ff <= mark_pos | (pend_pos_ff & !launch);
         pend_neg_ff <= mark_neg | (pend_neg_ff & !launch);
      end
   end

   assign rx_mark  = pend_pos_ff | pend_neg_ff;
   assign same_pol = rx_mark && (pend_pos_ff == rx_last_pol_ff);
   assign sub_v    = same_pol && zsub_ff && (zeros_ff >= 2'(ZRUN_SUB));
   assign viol     = same_pol && !sub_v;
   assign ais      = signal_loss_flag && sync_ff.host_mode && sync_ff.gcr_alarm_insert_enable;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rx_last_pol_ff <= 1'b0;
         zeros_ff       <= '0;
         ais_pol_ff     <= 1'b0;
      end else if (launch) begin
         if (rx_mark) begin
            rx_last_pol_ff <= pend_pos_ff;
            zeros_ff       <= '0;
         end else if (zeros_ff != 2'h3) begin
            zeros_ff <= zeros_ff + 2'h1;
         end
         ais_pol_ff <= !ais_pol_ff;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rx_pos_ff <= 1'b0;
         rx_neg_ff <= 1'b0;
      end else if (data_rec) begin
         rx_pos_ff <= sync_ff.rx_line_pos ^ !sync_ff.clock_edge_select;
         rx_neg_ff <= sync_ff.rx_line_neg ^ !sync_ff.clock_edge_select;
      end else if (launch) begin
         if (sync_ff.unipolar) begin
            rx_pos_ff <= ais | (rx_mark & !sub_v);
            rx_neg_ff <= !ais & viol;
         end else begin
            rx_pos_ff <= ais ? ais_pol_ff : pend_pos_ff;
            rx_neg_ff <= ais ? !ais_pol_ff : pend_neg_ff;
         end
      end
   end

   assign rx_clock_o         = rclk_ff;
   assign rx_positive_data_o = rx_pos_ff;
   assign rx_negative_data_o = rx_neg_ff;
   assign rx_clock_oe_o      = !sync_ff.mclk_held_low;
   assign rx_data_oe_o       = !sync_ff.mclk_held_low;
   assign unipolar_mode_o    = sync_ff.unipolar;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         host_bus_muxed_o <= 1'b0;
      end else begin
         host_bus_muxed_o <= sync_ff.bus_multiplex_select;
      end
   end
endmodule

// *** sim/lnp_line_port_sva.sv ***
// Concurrent checks on the line port's top-level ports.
// Assumes it is bound into lnp_line_port; one reference clock domain with synchronous reset.
`timescale 1ns/1ps
module lnp_line_port_sva
   import lnp_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic tx_line_clock_i,
   input wire logic tx_line_pos_o,
   input wire logic tx_line_neg_o,
   input wire logic tx_line_oe_o,
   input wire logic tx_shaping_disable_o,
   input wire logic mclk_held_high_i,
   input wire logic mclk_held_low_i,
   input wire logic clock_edge_select_i,
   input wire logic rx_line_pos_i,
   input wire logic rx_line_neg_i,
   input wire logic rx_clock_o,
   input wire logic rx_clock_oe_o,
   input wire logic rx_positive_data_o,
   input wire logic rx_negative_data_o,
   input wire logic rx_data_oe_o,
   input wire logic signal_loss_flag_o,
   input wire logic bus_multiplex_select_i,
   input wire logic host_bus_muxed_o
);
   logic [11:0] hi_cnt_ff;
   logic [11:0] lo_cnt_ff;
   logic [11:0] quiet_cnt_ff;
   logic        mark_ff;

   // Reference cycles the transmit clock has stood high, low, and since the last receive mark
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || !tx_line_clock_i) hi_cnt_ff <= 12'h000;
      else if (hi_cnt_ff != 12'hFFF) hi_cnt_ff <= hi_cnt_ff + 12'h001;
   end
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || tx_line_clock_i) lo_cnt_ff <= 12'h000;
      else if (lo_cnt_ff != 12'hFFF) lo_cnt_ff <= lo_cnt_ff + 12'h001;
   end
   always_ff @(posedge ref_clk_i) begin
      mark_ff <= rx_line_pos_i | rx_line_neg_i;
      if (rst_i || ((rx_line_pos_i | rx_line_neg_i) && !mark_ff)) quiet_cnt_ff <= 12'h000;
      else if (quiet_cnt_ff != 12'hFFF) quiet_cnt_ff <= quiet_cnt_ff + 12'h001;
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   no_dual_mark_a: assert property (!(tx_line_pos_o && tx_line_neg_o))
      else $error("tx line shows both marks at once");
   drv_idle_a: assert property (lo_cnt_ff >= DRV_IDLE_CYC + 4 |-> !tx_line_oe_o && !tx_line_pos_o && !tx_line_neg_o)
      else $error("driver still active with transmit clock parked low");
   shape_on_a: assert property (hi_cnt_ff >= SHAPE_STUCK_CYC + 4 |-> tx_shaping_disable_o)
      else $error("shaping not disabled with transmit clock parked high");
   shape_off_a: assert property (tx_shaping_disable_o |-> $past(hi_cnt_ff, 4) >= SHAPE_STUCK_CYC - 4)
      else $error("shaping disabled too early");
   clk_oe_a: assert property ($stable(mclk_held_low_i) [*3] |-> rx_clock_oe_o != mclk_held_low_i)
      else $error("receive clock enable does not follow master clock low");
   data_oe_a: assert property ($stable(mclk_held_low_i) [*3] |-> rx_data_oe_o != mclk_held_low_i)
      else $error("receive data enable does not follow master clock low");
   xor_clock_a: assert property (mclk_held_high_i [*4] |->
      rx_clock_o == (rx_positive_data_o ^ rx_negative_data_o) ||
      rx_clock_o == ($past(rx_positive_data_o) ^ $past(rx_negative_data_o)))
      else $error("receive clock is not the data exclusive-or");
   launch_edge_a: assert property ((clock_edge_select_i && !mclk_held_high_i && !signal_loss_flag_o) [*4]
      ##0 $changed(rx_positive_data_o) |-> $fell(rx_clock_o))
      else $error("receive data changed off the launch edge");
   loss_set_a: assert property (quiet_cnt_ff >= LOS_DETECT_CYC + 8 |-> signal_loss_flag_o)
      else $error("loss flag missing after quiet line");
   loss_rise_a: assert property ($rose(signal_loss_flag_o) |-> quiet_cnt_ff >= LOS_DETECT_CYC - 2)
      else $error("loss flag raised too early");
   loss_clock_a: assert property ((signal_loss_flag_o && !mclk_held_high_i) [*4] |-> rx_clock_o != $past(rx_clock_o))
      else $error("receive clock not on master clock during loss");
   bus_mux_a: assert property ($stable(bus_multiplex_select_i) [*4] |-> host_bus_muxed_o == bus_multiplex_select_i)
      else $error("bus multiplex mode does not follow select");
endmodule

// *** sim/lnp_framer_model.sv ***
// Far-end framer model: makes the transmit link clock and drives transmit data.
// Assumes mode 0 runs the clock, 1 parks it high, 2 parks it low; data toggles every 15 ns while parked.
`timescale 1ns/1ps
module lnp_framer_model
   import lnp_pkg::*;
(
   input  wire logic     [1:0] mode_i,
   input  wire lnp_sym_t       sym_i,
   output logic                tx_line_clock_o,
   output lnp_sym_t            tdata_o
);
   initial begin
      tx_line_clock_o = 1'b0;
      tdata_o = '0;
      #7;
      forever begin
         #15;
         if (mode_i == 2'h0) begin
            tx_line_clock_o = ~tx_line_clock_o;
         end else begin
            tx_line_clock_o = (mode_i == 2'h1);
            tdata_o = ~tdata_o;
         end
      end
   end

   // Data moves after the rising edge so the falling-edge sample sees it settled
   always @(posedge tx_line_clock_o) begin
      tdata_o <= sym_i;
   end
endmodule

// *** sim/lnp_line_port_test.sv ***
// Self-checking bench for the line port: transmit coding, receive modes, loss of signal, driver idle.
// Assumes the framer model on the transmit link and the checker bound at the foot of this file.
`timescale 1ns/1ps
module lnp_line_port_test;
   import lnp_pkg::*;
   logic       ref_clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       tx_line_clock_i;
   lnp_sym_t   tdat;
   lnp_sym_t   fr_sym = '0;
   logic [1:0] fr_mode = 2'h0;
   logic       code_select_i = 1'b0, host_mode_i = 1'b0, gcr_code_select_i = 1'b0;
   logic       gcr_alarm_insert_enable_i = 1'b0, mclk_held_high_i = 1'b0, mclk_held_low_i = 1'b0;
   logic       clock_edge_select_i = 1'b1, rx_line_pos_i = 1'b0, rx_line_neg_i = 1'b0;
   logic       bus_multiplex_select_i = 1'b0;
   logic [2:0] rcnt = 3'h0;
   wire        rx_recovered_clk_i = rcnt[2];
   logic       tx_ready_o, tx_line_pos_o, tx_line_neg_o, tx_line_oe_o, tx_shaping_disable_o, unipolar_mode_o;
   logic       rx_clock_o, rx_clock_oe_o, rx_positive_data_o, rx_negative_data_o, rx_data_oe_o;
   logic       signal_loss_flag_o, host_bus_muxed_o;
   logic [2:0] cs [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
   int         fail_count = 0, comparisons = 0, pc, nc, rp, rn, ct, full;

   lnp_framer_model i_far (.mode_i(fr_mode), .sym_i(fr_sym), .tx_line_clock_o(tx_line_clock_i), .tdata_o(tdat));
   lnp_line_port i_dut (
      .ref_clk_i, .rst_i, .tx_line_clock_i, .tx_positive_data_i(tdat.pos), .tx_negative_data_i(tdat.neg),
      .tx_ready_o, .code_select_i, .host_mode_i, .gcr_code_select_i, .gcr_alarm_insert_enable_i,
      .tx_line_pos_o, .tx_line_neg_o, .tx_line_oe_o, .tx_shaping_disable_o, .unipolar_mode_o,
      .mclk_held_high_i, .mclk_held_low_i, .clock_edge_select_i, .rx_line_pos_i, .rx_line_neg_i,
      .rx_recovered_clk_i, .rx_clock_o, .rx_clock_oe_o, .rx_positive_data_o, .rx_negative_data_o,
      .rx_data_oe_o, .signal_loss_flag_o, .bus_multiplex_select_i, .host_bus_muxed_o
   );

   initial begin
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) begin
      rcnt <= rcnt + 3'h1;
   end

   task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   // Counts, over n cycles, the cycles with each line and receive data output active, with tx_ready_o low, and the receive clock changes
   task run(input int n);
      logic last;
      {pc, nc, rp, rn, ct, full} = '0;
      repeat (n) begin
         last = rx_clock_o;
         @(posedge ref_clk_i);
         #1;
         pc += int'(tx_line_pos_o === 1'b1);
         nc += int'(tx_line_neg_o === 1'b1);
         rp += int'(rx_positive_data_o === 1'b1);
         rn += int'(rx_negative_data_o === 1'b1);
         ct += int'(rx_clock_o !== last);
         full += int'(tx_ready_o === 1'b0);
      end
   endtask

   task pulse(input logic p, input logic n, input int w);
      @(posedge ref_clk_i);
      rx_line_pos_i <= p;
      rx_line_neg_i <= n;
      run(w);
      rx_line_pos_i <= 1'b0;
      rx_line_neg_i <= 1'b0;
   endtask

   task neg_burst(input int n);
      @(posedge tx_line_clock_i);
      fr_sym <= 2'h1;
      repeat (n) @(posedge tx_line_clock_i);
      fr_sym <= 2'h0;
   endtask

   task results();
      if (fail_count == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      #800000;
      fail_count++;
      results();
   end

   initial begin
      repeat (6) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      run(8);
      chk("rx_clock_oe", 1, rx_clock_oe_o);
      chk("rx_data_oe", 1, rx_data_oe_o);
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk_i);
         fr_sym <= i[1:0];
         repeat (2) @(posedge ref_clk_i);
         fr_sym <= 2'h0;
         run(14);
         chk("tx_mark", {i == 2, i == 1}, {pc > 0, nc > 0});
      end
      neg_burst(16);
      run(12);
      chk("unipolar_16", 0, unipolar_mode_o);
      @(posedge ref_clk_i);
      fr_sym <= 2'h1;
      run(30);
      chk("unipolar_17", 1, unipolar_mode_o);
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk_i);
         {host_mode_i, code_select_i, gcr_code_select_i} <= cs[i];
         run(40);
         run(80);
         chk("zero_subst", cs[i][2] ? cs[i][0] : cs[i][1], (pc + nc) > 0);
      end
      @(posedge ref_clk_i);
      fr_sym <= 2'h3;
      run(60);
      chk("ami_alternate", 3, {pc > 0, nc > 0});
      chk("fifo_refused", 1, full > 0);
      @(posedge ref_clk_i);
      fr_sym <= 2'h0;
      run(12);
      chk("unipolar_off", 0, unipolar_mode_o);
      @(posedge ref_clk_i);
      fr_mode <= 2'h1;
      run(240);
      chk("shaping_early", 0, tx_shaping_disable_o);
      run(40);
      chk("shaping_off", 1, tx_shaping_disable_o);
      @(posedge ref_clk_i);
      fr_mode <= 2'h2;
      run(10);
      chk("driver_on", 1, tx_line_oe_o);
      run(20);
      chk("driver_idle", 0, {tx_line_oe_o, tx_shaping_disable_o});
      @(posedge ref_clk_i);
      fr_mode <= 2'h0;
      run(10);
      chk("driver_back", 1, tx_line_oe_o);
      pulse(1'b1, 1'b0, 2);
      run(20);
      chk("rx_nrz_pos", 2, {rp > 0, rn > 0});
      pulse(1'b0, 1'b1, 2);
      run(20);
      chk("rx_nrz_neg", 1, rn > 0);
      chk("rx_clock_run", 1, ct > 3);
      @(posedge ref_clk_i);
      mclk_held_high_i <= 1'b1;
      clock_edge_select_i <= 1'b0;
      run(6);
      chk("rz_idle_low", 3, {rx_positive_data_o, rx_negative_data_o});
      @(posedge ref_clk_i);
      clock_edge_select_i <= 1'b1;
      run(4);
      pulse(1'b0, 1'b1, 6);
      chk("rz_pulse", 1, rn > 0);
      chk("xor_clock", 1, ct > 0);
      run(6);
      chk("rz_idle_high", 0, {rx_positive_data_o, rx_negative_data_o});
      @(posedge ref_clk_i);
      mclk_held_low_i <= 1'b1;
      bus_multiplex_select_i <= 1'b1;
      run(6);
      chk("rx_oe_off", 0, {rx_clock_oe_o, rx_data_oe_o});
      chk("bus_mux", 1, host_bus_muxed_o);
      @(posedge ref_clk_i);
      mclk_held_low_i <= 1'b0;
      mclk_held_high_i <= 1'b0;
      bus_multiplex_select_i <= 1'b0;
      run(2600);
      chk("loss_early", 0, signal_loss_flag_o);
      run(300);
      chk("loss_set", 1, signal_loss_flag_o);
      @(posedge ref_clk_i);
      host_mode_i <= 1'b1;
      gcr_alarm_insert_enable_i <= 1'b1;
      run(40);
      chk("alarm_marks", 3, {rp > 0, rn > 0});
      chk("loss_clock", 1, ct > 30);
      @(posedge ref_clk_i);
      host_mode_i <= 1'b0;
      run(10);
      run(40);
      chk("hw_no_alarm", 0, {rp > 0, rn > 0});
      for (int k = 0; k < 1200 && signal_loss_flag_o !== 1'b0; k++) begin
         pulse(k[0], !k[0], 2);
         run(5);
      end
      chk("loss_clear", 0, signal_loss_flag_o);
      results();
   end
endmodule

bind lnp_line_port lnp_line_port_sva i_sva (
   .ref_clk_i, .rst_i, .tx_line_clock_i, .tx_line_pos_o, .tx_line_neg_o, .tx_line_oe_o, .tx_shaping_disable_o,
   .mclk_held_high_i, .mclk_held_low_i, .clock_edge_select_i, .rx_line_pos_i, .rx_line_neg_i, .rx_clock_o,
   .rx_clock_oe_o, .rx_positive_data_o, .rx_negative_data_o, .rx_data_oe_o, .signal_loss_flag_o,
   .bus_multiplex_select_i, .host_bus_muxed_o
);
